// ===== rtl/rpp_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef RPP_MAP_SVH
`define RPP_MAP_SVH
// ****************************************************************
// global registers
// ****************************************************************
`define RPP_SH_MAX 8'h00
`define RPP_SH_BASE 8'h04
`define RPP_SH_TRAP 8'h08
`define RPP_SH_SCRV 8'h0c
`define RPP_CNT_OP 8'h10
`define RPP_FRQ_OP 8'h14
`define RPP_CTRL 8'h18
`define RPP_STAT 8'h1c
// ****************************************************************
// per-axis block: base 0x40, stride 0x20, word index in addr[4:2]
// ****************************************************************
`define RPP_AX_FIRST 3'h2
`define RPP_AX_POS 3'h0
`define RPP_AX_MAX 3'h1
`define RPP_AX_BASE 3'h2
`define RPP_AX_ACC 3'h3
`define RPP_AX_DEC 3'h4
`define RPP_AX_CTL 3'h5
// ****************************************************************
// field positions
// ****************************************************************
`define RPP_CTRL_EN 0
`define RPP_CTRL_WIDE 4
`define RPP_AXC_SCRV 0
`define RPP_AXC_SEP 1
`define RPP_AXC_STOP 2
`define RPP_STAT_DONE 8
// ****************************************************************
// reset values and ranges
// ****************************************************************
`define RPP_RST_MAX 32'd200000
`define RPP_RST_BASE 16'd500
`define RPP_RST_RAMP 16'd100
`define RPP_F_MIN 32'd10
`define RPP_F_MAX_N 32'd32767
`define RPP_F_MAX_W 32'd200000
`define RPP_RAMP_MIN 32'd10
`define RPP_RAMP_MAX 32'd5000
// ****************************************************************
// timing
// ****************************************************************
`define RPP_CLK_NS 40
`define RPP_MS_NS 1000000
`define RPP_S_NS 1000000000
`endif

// ===== rtl/rpp_pkg.sv
// types shared by the relative pulse positioner
package rpp_pkg;
    // register bus request from software
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } rpp_bus_t;
    // move engine states, gray along idle-accel-run-decel
    typedef enum logic [1:0] {
        RPP_IDLE = 2'b00,
        RPP_ACCEL = 2'b01,
        RPP_RUN = 2'b11,
        RPP_DECEL = 2'b10
    } rpp_state_t;
    // per-axis parameter set
    typedef struct packed {
        logic [31:0] max_spd;
        logic [15:0] base_spd;
        logic [15:0] acc_ms;
        logic [15:0] dec_ms;
        logic [2:0] ctl;
    } rpp_axis_t;
endpackage

// ===== rtl/rpp_top.sv
// relative move pulse train generator for five output axes
// ****************************************************************
// Summary of operation
// [R01] narrow form takes the pulse count as a signed 16-bit value
// [R02] wide form takes the pulse count as a full signed 32-bit value
// [R03] a negative count means reverse travel; magnitude is pulse number
// [R04] the count is an offset from the axis position, not a target
// [R05] position counts up on forward pulses and down on reverse ones
// [R06] narrow form frequency is held to 10 through 32767 Hz
// [R07] wide form frequency is held to 10 through 200000 Hz
// [R08] five output ports, the chosen port selects axis registers
// [R09] direction output is high forward and low reverse
// [R10] operands are latched at start; later writes wait for next move
// [R11] enable dropping mid-move ramps the frequency down to a stop
// [R12] a move ended by enable dropping leaves the done flag alone
// [R13] once enable drops during a move, enable no longer steers it
// [R14] per-axis busy is set while pulsing and clears itself at the end
// [R15] per-axis s-curve bit picks the profile, trapezoid when clear
// [R16] s-curve mode recomputes each pulse period from the ramp
// [R17] ramp times are held to 10 through 5000 ms
// [R18] trapezoid and s-curve ramp times are kept apart
// [R19] separate bit off uses the shared max, base and ramp registers
// [R20] separate bit on uses that axis's own parameter registers
// [R21] axis registers reset to 200000 Hz, 500 Hz, 100 ms and 100 ms
// [R22] the axis stop bit halts pulse output on that axis
// [R23] pulse period comes from the clock and ramp frequency, 50 % duty
// [R24] a zero count finishes at once with no pulse and no move
// ****************************************************************
//
// The plain strobed port and the register addresses were left to the implementer.
`include "rpp_map.svh"
module rpp_top #(
    parameter int NAX = 5,
    parameter int CLK_HZ = `RPP_S_NS / `RPP_CLK_NS,
    parameter int CYC_PER_MS = `RPP_MS_NS / `RPP_CLK_NS
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire rpp_pkg::rpp_bus_t bus,
    output logic [31:0] rdata,
    // drive side
    output logic [NAX-1:0] pulse_out,
    output logic [NAX-1:0] dir_out,
    output logic [NAX-1:0] busy
);
    import rpp_pkg::*;

    // ************************************************************
    // helpers
    // ************************************************************
    // clamp a value into an inclusive range
    function automatic logic [31:0] clamp(input logic [31:0] v,
                                          input logic [31:0] lo,
                                          input logic [31:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // ************************************************************
    // register file
    // ************************************************************
    logic [31:0] sh_max_q;
    logic [15:0] sh_base_q;
    logic [15:0] sh_trap_q;
    logic [15:0] sh_scrv_q;
    logic [31:0] cnt_op_q;
    logic [31:0] frq_op_q;
    logic [4:0] ctrl_q;
    logic done_q;
    rpp_axis_t ax_q [NAX];
    logic [31:0] pos_q [NAX];
    logic [31:0] rdata_q;

    // address decode
    wire logic [2:0] ax_blk = bus.addr[7:5] - `RPP_AX_FIRST;
    wire logic [2:0] ax_sub = bus.addr[4:2];
    wire logic ax_hit = (bus.addr[7:5] >= `RPP_AX_FIRST) &&
                        (int'(ax_blk) < NAX) && (bus.addr[1:0] == 2'h0);
    wire logic wr_g = bus.wr && (bus.addr[7:5] == 3'h0);

    // read selection
    logic [31:0] rd_ax;
    logic [31:0] rd_gl;
    always_comb begin
        rd_ax = 32'h0;
        if (ax_hit) begin
            case (ax_sub)
                `RPP_AX_POS: rd_ax = pos_q[ax_blk];
                `RPP_AX_MAX: rd_ax = ax_q[ax_blk].max_spd;
                `RPP_AX_BASE: rd_ax = {16'h0, ax_q[ax_blk].base_spd};
                `RPP_AX_ACC: rd_ax = {16'h0, ax_q[ax_blk].acc_ms};
                `RPP_AX_DEC: rd_ax = {16'h0, ax_q[ax_blk].dec_ms};
                `RPP_AX_CTL: rd_ax = {29'h0, ax_q[ax_blk].ctl};
                default: rd_ax = 32'h0;
            endcase
        end
    end
    always_comb begin
        case (bus.addr)
            `RPP_SH_MAX: rd_gl = sh_max_q;
            `RPP_SH_BASE: rd_gl = {16'h0, sh_base_q};
            `RPP_SH_TRAP: rd_gl = {16'h0, sh_trap_q};
            `RPP_SH_SCRV: rd_gl = {16'h0, sh_scrv_q};
            `RPP_CNT_OP: rd_gl = cnt_op_q;
            `RPP_FRQ_OP: rd_gl = frq_op_q;
            `RPP_CTRL: rd_gl = {27'h0, ctrl_q};
            `RPP_STAT: rd_gl = {23'h0, done_q, 3'h0, busy};
            default: rd_gl = rd_ax;
        endcase
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clock) begin
        if (rst) rdata_q <= 32'h0;
        else rdata_q <= bus.rd ? rd_gl : 32'h0;
    end
    assign rdata = rdata_q;

    // shared registers and operands, written at any time
    always_ff @(posedge clock) begin
        if (rst) begin
            sh_max_q <= `RPP_RST_MAX;
            sh_base_q <= `RPP_RST_BASE;
            sh_trap_q <= `RPP_RST_RAMP;
            sh_scrv_q <= `RPP_RST_RAMP;
            cnt_op_q <= 32'h0;
            frq_op_q <= 32'h0;
            ctrl_q <= 5'h0;
        end else if (wr_g) begin
            case (bus.addr)
                `RPP_SH_MAX: sh_max_q <= bus.wdata;
                `RPP_SH_BASE: sh_base_q <= bus.wdata[15:0];
                `RPP_SH_TRAP: sh_trap_q <= bus.wdata[15:0];
                `RPP_SH_SCRV: sh_scrv_q <= bus.wdata[15:0];
                `RPP_CNT_OP: cnt_op_q <= bus.wdata;
                `RPP_FRQ_OP: frq_op_q <= bus.wdata;
                `RPP_CTRL: ctrl_q <= bus.wdata[4:0];
                default: ;
            endcase
        end
    end

    // per-axis parameters, reset to the documented defaults
    always_ff @(posedge clock) begin
        for (int i = 0; i < NAX; i++) begin
            if (rst) begin
                ax_q[i].max_spd <= `RPP_RST_MAX; // [R21]
                ax_q[i].base_spd <= `RPP_RST_BASE; // [R21]
                ax_q[i].acc_ms <= `RPP_RST_RAMP; // [R21]
                ax_q[i].dec_ms <= `RPP_RST_RAMP; // [R21]
                ax_q[i].ctl <= 3'h0; // [R19]
            end else if (bus.wr && ax_hit && int'(ax_blk) == i) begin
                case (ax_sub)
                    `RPP_AX_MAX: ax_q[i].max_spd <= bus.wdata;
                    `RPP_AX_BASE: ax_q[i].base_spd <= bus.wdata[15:0];
                    `RPP_AX_ACC: ax_q[i].acc_ms <= bus.wdata[15:0];
                    `RPP_AX_DEC: ax_q[i].dec_ms <= bus.wdata[15:0];
                    `RPP_AX_CTL: ax_q[i].ctl <= bus.wdata[2:0];
                    default: ;
                endcase
            end
        end
    end

    // ************************************************************
    // move start and operand latch
    // ************************************************************
    rpp_state_t st_q;
    logic en_prev_q;
    logic detach_q;
    logic [2:0] axis_q;
    logic neg_q;
    logic scrv_q;
    logic [31:0] rem_q;
    logic [31:0] acc_pul_q;
    logic [17:0] f_q;
    logic [17:0] f_use_q;
    logic [17:0] tgt_q;
    logic [17:0] base_q;
    logic [31:0] acc_den_q;
    logic [31:0] dec_den_q;
    logic [31:0] err_q;
    logic [25:0] ph_acc_q;
    logic ph_q;

    wire logic en = ctrl_q[`RPP_CTRL_EN];
    wire logic en_rise = en && !en_prev_q;
    wire logic [2:0] port = ctrl_q[3:1];
    wire logic wide = ctrl_q[`RPP_CTRL_WIDE];
    wire logic [31:0] cnt_s = wide ? cnt_op_q // [R02]
                            : {{16{cnt_op_q[15]}}, cnt_op_q[15:0]}; // [R01]
    wire logic cnt_neg = cnt_s[31]; // [R03]
    wire logic [31:0] cnt_mag = cnt_neg ? (32'h0 - cnt_s) : cnt_s; // [R03]
    wire logic [31:0] frq_in = wide ? frq_op_q
                             : {16'h0, frq_op_q[15:0]};
    wire logic [31:0] frq_c = clamp(frq_in, `RPP_F_MIN,
                              wide ? `RPP_F_MAX_W : `RPP_F_MAX_N); // [R06] [R07]
    wire logic port_ok = int'(port) < NAX; // [R08]
    wire logic start = en_rise && (st_q == RPP_IDLE) && port_ok;

    // parameter source for the selected axis
    wire rpp_axis_t sel_ax = ax_q[port];
    wire logic sep = sel_ax.ctl[`RPP_AXC_SEP]; // [R19] [R20]
    wire logic sel_scrv = sel_ax.ctl[`RPP_AXC_SCRV]; // [R15]
    wire logic [31:0] p_max = sep ? sel_ax.max_spd : sh_max_q;
    wire logic [31:0] p_base = sep ? {16'h0, sel_ax.base_spd}
                                   : {16'h0, sh_base_q};
    wire logic [15:0] sh_ramp = sel_scrv ? sh_scrv_q : sh_trap_q; // [R18]
    wire logic [31:0] p_acc = clamp({16'h0, sep ? sel_ax.acc_ms : sh_ramp},
                                    `RPP_RAMP_MIN, `RPP_RAMP_MAX); // [R17]
    wire logic [31:0] p_dec = clamp({16'h0, sep ? sel_ax.dec_ms : sh_ramp},
                                    `RPP_RAMP_MIN, `RPP_RAMP_MAX); // [R17]
    wire logic [31:0] tgt_c = clamp(frq_c, `RPP_F_MIN,
                                    clamp(p_max, `RPP_F_MIN, `RPP_F_MAX_W));
    wire logic [31:0] base_c = (p_base > tgt_c) ? tgt_c
                             : clamp(p_base, `RPP_F_MIN, tgt_c);

    // ************************************************************
    // ramp and pulse engine
    // ************************************************************
    wire logic [31:0] ramp_diff = {14'h0, tgt_q - base_q};
    wire logic [31:0] den = (st_q == RPP_DECEL) ? dec_den_q : acc_den_q;
    wire logic [31:0] err_n = err_q + ramp_diff;
    wire logic ramp_step = err_n >= den;
    wire logic [17:0] f_run = scrv_q ? f_use_q : f_q; // [R16]
    wire logic [25:0] ph_sum = ph_acc_q + {7'h0, f_run, 1'b0};
    wire logic toggle = (st_q != RPP_IDLE) && (ph_sum >= 26'(CLK_HZ)); // [R23]
    wire logic rise = toggle && !ph_q;
    wire logic fall = toggle && ph_q;
    wire logic stop_req = ax_q[axis_q].ctl[`RPP_AXC_STOP]; // [R22]
    wire logic [31:0] rem_n = rise ? rem_q - 32'h1 : rem_q;
    wire logic need_dec = rem_n <= acc_pul_q;
    wire logic end_cnt = fall && (rem_q == 32'h0);
    wire logic end_det = fall && detach_q && (f_q == base_q); // [R11]
    wire logic finish = (st_q != RPP_IDLE) && (end_cnt || end_det);
    wire logic abort = (st_q != RPP_IDLE) && stop_req; // [R22]
    wire logic [18:0] f_gap = {1'b0, f_q} - {1'b0, f_use_q};
    wire logic [18:0] f_half = {f_gap[18], f_gap[18:1]};

    // next state of the move sequencer
    rpp_state_t st_d;
    always_comb begin
        st_d = st_q;
        case (st_q)
            RPP_IDLE: if (start && cnt_mag != 32'h0) st_d = RPP_ACCEL; // [R24]
            RPP_ACCEL: begin
                if (!en || need_dec) st_d = RPP_DECEL; // [R11]
                else if (f_q >= tgt_q) st_d = RPP_RUN;
            end
            RPP_RUN: if (!en || need_dec) st_d = RPP_DECEL; // [R11]
            RPP_DECEL: st_d = RPP_DECEL;
            default: st_d = RPP_IDLE;
        endcase
        if (finish || abort) st_d = RPP_IDLE; // [R14]
    end

    // sequencer, latched operands and enable tracking
    always_ff @(posedge clock) begin
        if (rst) begin
            st_q <= RPP_IDLE;
            en_prev_q <= 1'b0;
            detach_q <= 1'b0;
            axis_q <= 3'h0;
            neg_q <= 1'b0;
            scrv_q <= 1'b0;
            tgt_q <= 18'h0;
            base_q <= 18'h0;
            acc_den_q <= 32'h0;
            dec_den_q <= 32'h0;
        end else begin
            st_q <= st_d;
            en_prev_q <= en;
            if (start) begin // [R10]
                axis_q <= port; // [R08]
                neg_q <= cnt_neg;
                scrv_q <= sel_scrv; // [R15]
                tgt_q <= tgt_c[17:0];
                base_q <= base_c[17:0];
                acc_den_q <= 32'(p_acc * CYC_PER_MS);
                dec_den_q <= 32'(p_dec * CYC_PER_MS);
            end
            // enable loses its hold once it drops during a move
            if (st_d == RPP_IDLE) detach_q <= 1'b0;
            else if (st_q != RPP_IDLE && !en) detach_q <= 1'b1; // [R13]
        end
    end

    // pulse counts and frequency ramp
    always_ff @(posedge clock) begin
        if (rst) begin
            rem_q <= 32'h0;
            acc_pul_q <= 32'h0;
            f_q <= 18'h0;
            f_use_q <= 18'h0;
            err_q <= 32'h0;
        end else if (start) begin
            rem_q <= cnt_mag; // [R04]
            acc_pul_q <= 32'h0;
            f_q <= base_c[17:0];
            f_use_q <= base_c[17:0];
            err_q <= 32'h0;
        end else if (st_q != RPP_IDLE) begin
            rem_q <= rem_n;
            if (rise && st_q == RPP_ACCEL) acc_pul_q <= acc_pul_q + 32'h1;
            err_q <= ramp_step ? err_n - den : err_n;
            if (ramp_step && st_q == RPP_ACCEL && f_q < tgt_q)
                f_q <= f_q + 18'h1;
            else if (ramp_step && st_q == RPP_DECEL && f_q > base_q)
                f_q <= f_q - 18'h1; // [R11]
            // s-curve period follows the ramp once per pulse
            if (rise) f_use_q <= 18'({1'b0, f_use_q} + f_half); // [R16]
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    logic [NAX-1:0] pulse_q;
    logic [NAX-1:0] dir_q;
    logic [NAX-1:0] busy_q;
    wire logic fin_ok = finish && !detach_q && !abort; // [R12]

    // phase accumulator at 50 % duty and position tracking
    always_ff @(posedge clock) begin
        if (rst) begin
            ph_acc_q <= 26'h0;
            ph_q <= 1'b0;
            for (int i = 0; i < NAX; i++) pos_q[i] <= 32'h0;
        end else if (st_q == RPP_IDLE || abort) begin
            ph_acc_q <= 26'h0;
            ph_q <= 1'b0;
        end else begin
            ph_acc_q <= toggle ? ph_sum - 26'(CLK_HZ) : ph_sum; // [R23]
            if (toggle) ph_q <= !ph_q;
            if (rise) pos_q[axis_q] <= neg_q ? pos_q[axis_q] - 32'h1 // [R05]
                                             : pos_q[axis_q] + 32'h1;
        end
    end

    // drive lines and status flags
    always_ff @(posedge clock) begin
        if (rst) begin
            pulse_q <= '0;
            dir_q <= '0;
            busy_q <= '0;
            done_q <= 1'b0;
        end else begin
            for (int i = 0; i < NAX; i++) begin
                pulse_q[i] <= (st_d != RPP_IDLE) && (int'(axis_q) == i) &&
                              (toggle ? !ph_q : ph_q);
                if (start && int'(port) == i) dir_q[i] <= !cnt_neg; // [R09]
                busy_q[i] <= (st_d != RPP_IDLE) &&
                             (int'(start ? port : axis_q) == i); // [R14]
            end
            // done set on a counted end or zero count; set beats clear
            if (fin_ok || (start && cnt_mag == 32'h0)) done_q <= 1'b1; // [R24]
            else if (start) done_q <= 1'b0;
            else if (wr_g && bus.addr == `RPP_STAT &&
                     bus.wdata[`RPP_STAT_DONE]) done_q <= 1'b0;
        end
    end
    assign pulse_out = pulse_q;
    assign dir_out = dir_q;
    assign busy = busy_q;

    // ************************************************************
    // checks
    // ************************************************************
    logic [31:0] pos_past;
    assign pos_past = pos_q[axis_q];
    AST_DIR_REV: assert property (@(posedge clock) disable iff (rst) // [R09]
        (st_q != RPP_IDLE && neg_q) |-> !dir_q[axis_q])
        else $error("direction not low on reverse move");
    AST_POS_STEP: assert property (@(posedge clock) disable iff (rst) // [R05]
        (rise && !abort) |=> (pos_q[axis_q] - $past(pos_past) ==
                              ($past(neg_q) ? 32'hffffffff : 32'h1)))
        else $error("position did not step by one");
    AST_STOP: assert property (@(posedge clock) disable iff (rst) // [R22]
        (st_q != RPP_IDLE && stop_req) |=> ##1 busy_q == '0)
        else $error("stop bit did not halt output");
    AST_ZERO: assert property (@(posedge clock) disable iff (rst) // [R24]
        (start && cnt_mag == 32'h0) |=> (done_q && busy_q == '0) [*2])
        else $error("zero count did not finish at once");
    AST_DETACH_DONE: assert property (@(posedge clock) disable iff (rst)
        (detach_q && !start && !wr_g) |=> $stable(done_q)) // [R12]
        else $error("done changed after enable dropped");
    AST_DETACH_HOLD: assert property (@(posedge clock) disable iff (rst)
        (detach_q && st_d != RPP_IDLE) |=> detach_q && st_q == RPP_DECEL)
        else $error("enable steered a detached move"); // [R13]
    AST_FREQ: assert property (@(posedge clock) disable iff (rst) // [R07]
        (st_q != RPP_IDLE) |-> (f_q >= 18'd10 && f_q <= 18'd200000))
        else $error("frequency out of range");
    AST_DECEL_DOWN: assert property (@(posedge clock) disable iff (rst)
        (st_q == RPP_DECEL && !start) |=> (f_q <= $past(f_q))) // [R11]
        else $error("frequency rose while slowing");
    AST_LATCH: assert property (@(posedge clock) disable iff (rst) // [R10]
        (st_q != RPP_IDLE && !rise) |=> $stable(rem_q) && $stable(neg_q))
        else $error("latched operands changed mid-move");
    AST_BUSY: assert property (@(posedge clock) disable iff (rst) // [R14]
        $fell(st_q != RPP_IDLE) |-> busy_q == '0)
        else $error("busy not cleared at move end");
endmodule

// ===== test/rpp_servo_model.sv
// servo drive model: counts pulse rises per axis
module rpp_servo_model #(
    parameter int NAX = 5
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // drive inputs
    input wire logic [NAX-1:0] pulse_out,
    input wire logic [NAX-1:0] dir_out,
    // travelled position
    output int pos [NAX]
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [NAX-1:0] prev_q;
    // one step per rising pulse, sign from the direction line
    always @(posedge clock) begin
        prev_q <= pulse_out;
        for (int i = 0; i < NAX; i++) begin
            if (rst) begin
                pos[i] <= 0;
            end else if (pulse_out[i] && !prev_q[i]) begin
                pos[i] <= pos[i] + (dir_out[i] ? 1 : -1);
            end
        end
    end
endmodule

// ===== test/relative_pulse_positioner_tb_top.sv
// self-checking bench for the relative pulse positioner
`include "rpp_map.svh"
module relative_pulse_positioner_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rpp_pkg::*;
    logic clock, rst;
    rpp_bus_t bus;
    logic [31:0] rdata, d;
    logic [4:0] pulse_out, dir_out, busy;
    int pos [5];
    int exp_pos [5];
    int miscompares, n_tests, seed, c;
    logic [7:0] ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h44, 8'h48,
        8'h4c, 8'h50, 8'h54, 8'h3c};
    int rv [10] = '{200000, 500, 100, 100, 200000, 500, 100, 100, 0, 0};
    // ****************************************************************
    // design and drive model
    // ****************************************************************
    rpp_top #(.NAX(5), .CLK_HZ(1000), .CYC_PER_MS(10)) i_dut (
        .clock(clock), .rst(rst), .bus(bus), .rdata(rdata),
        .pulse_out(pulse_out), .dir_out(dir_out), .busy(busy));
    rpp_servo_model #(.NAX(5)) i_servo (
        .clock(clock), .rst(rst), .pulse_out(pulse_out),
        .dir_out(dir_out), .pos(pos));
    // clock generator
    initial begin
        clock = 0;
        forever #20 clock = ~clock;
    end
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s %0h vs %0h", $time, what, seen,
                exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        bus <= '{a, v, 1'b1, 1'b0};
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clock);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wait_busy(input int p, input logic v, input int n);
        for (int i = 0; i < n && busy[p] !== v; i++) begin
            @(posedge clock);
            #1;
        end
        chk(busy[p], v, "busy");
    endtask
    task automatic start(input int p, input logic [31:0] n, input logic w);
        wr(`RPP_CTRL, 32'h0);
        wr(`RPP_CNT_OP, n);
        wr(`RPP_FRQ_OP, 32'd100);
        wr(`RPP_CTRL, {27'h0, w, 3'(p), 1'b1});
        wait_busy(p, 1'b1, 2);
    endtask
    task automatic finish(input int p, input int n);
        wait_busy(p, 1'b0, 3000);
        exp_pos[p] += n;
        chk(dir_out[p], 1'(n >= 0), "direction");
        rd(`RPP_STAT);
        chk(d[`RPP_STAT_DONE], 1'b1, "done");
        rd(8'h40 + 8'(p * 32));
        chk(d, exp_pos[p], "position");
        chk(pos[p], exp_pos[p], "pulses");
    endtask
    task automatic conclude;
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (40000) @(posedge clock);
        miscompares++;
        conclude;
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        bus = '0;
        rst = 1;
        seed = 30904;
        exp_pos = '{default: 0};
        repeat (20) @(posedge clock);
        rst <= 0;
        // reset values and an unmapped place
        for (int i = 0; i < 10; i++) begin
            rd(ra[i]);
            chk(d, rv[i], "reset value");
        end
        wr(`RPP_SH_BASE, 32'd100);
        // two moves per port, offset from the last position
        for (int p = 0; p < 5; p++) begin
            for (int k = 0; k < 2; k++) begin
                c = $random(seed) % 7;
                if (c == 0) c = 3;
                start(p, c, 1'b0);
                if (k == 1) wr(`RPP_CNT_OP, 32'h7);
                finish(p, c);
            end
        end
        start(0, 32'h0001fffd, 1'b0);
        finish(0, -3);
        start(1, 32'hfffffff9, 1'b1);
        finish(1, -7);
        // zero count finishes at once
        wr(`RPP_CTRL, 32'h0);
        wr(`RPP_CNT_OP, 32'h0);
        wr(`RPP_CTRL, 32'h5);
        repeat (3) @(posedge clock);
        #1 chk(busy, 5'h0, "zero busy");
        rd(`RPP_STAT);
        chk(d[`RPP_STAT_DONE], 1'b1, "zero done");
        // software clears the done flag
        wr(`RPP_STAT, 32'h100);
        rd(`RPP_STAT);
        chk(d[`RPP_STAT_DONE], 1'b0, "done cleared");
        // axis 3 own set: s-curve ramp from 20 Hz, 10 ms each way
        wr(8'ha8, 32'd20);
        wr(8'hac, 32'd10);
        wr(8'hb0, 32'd10);
        wr(8'hb4, 32'h3);
        start(3, 30, 1'b0);
        finish(3, 30);
        // enable dropped mid-move, then stop bit mid-move
        for (int p = 1; p < 5; p += 3) begin
            start(p, 40, 1'b0);
            repeat (60) @(posedge clock);
            if (p == 1) wr(`RPP_CTRL, 32'h0);
            else wr(8'h54 + 8'(p * 32), 32'h4);
            wait_busy(p, 1'b0, p == 1 ? 100 : 2);
            rd(`RPP_STAT);
            chk(d[`RPP_STAT_DONE], 1'b0, "done kept");
            rd(8'h40 + 8'(p * 32));
            chk(d, pos[p], "stopped position");
            chk(1'(pos[p] - exp_pos[p] < 40), 1'b1, "cut short");
            exp_pos[p] = pos[p];
        end
        wr(8'hd4, 32'h0);
        // position is read-only
        wr(8'h40, 32'h55);
        rd(8'h40);
        chk(d, exp_pos[0], "read-only");
        conclude;
    end
endmodule
